/* File: common/i2c_seq_pkg.sv */
// constants, states and pin carrier for the two-wire master sequencer
// How it works
// RULE1: start-seen and stop-seen clear on reset and while the port is disabled.
// RULE2: software takes the bus only after a stop or when the bus is idle.
// RULE3: irq flag sets on start, stop, byte done, ack sent and repeated start; the code has no receive path, so no ack-sent source.
// RULE4: software selects master mode and sets the enable bit before requests.
// RULE5: no queued events; early buffer write is dropped and sets write collision.
// RULE6: baud counter loads reload bits 6:0, counts to zero, then stops.
// RULE7: baud counter decrements on the second and fourth quarter phases.
// RULE8: reload is automatic; during arbitration only after SCL is seen high.
// RULE9: counting starts on buffer write, stops after the ack, SCL kept.
// RULE10: start request with both lines high reloads and starts counting.
// RULE11: interval end with lines high pulls SDA low, sets start-seen, reloads.
// RULE12: second interval end clears start request, stops counter, SDA kept low.
// RULE13: lines low at start or SCL low before SDA low gives bus collision.
// RULE14: buffer writes during a start are dropped and set write collision.
// RULE15: low five control bits ignore writes until the start completes.
// RULE16: restart pulls SCL low, then loads bits 5:0 and releases SDA.
// RULE17: SDA high releases SCL; SCL high reloads, holds, then SDA low.
// RULE18: restart ends without reload, SDA low, start-seen early, irq at timeout.
// RULE19: restart request is ignored while another event runs.
// RULE20: SDA low at SCL rise or SCL low before SDA low gives collision.
// RULE21: during restart, buffer writes dropped, write collision, control locked.
// RULE22: first byte is address plus direction, then bytes each with an ack.
// RULE23: slave ack lands in control bit 6, irq at end of the ninth clock.
// RULE24: enabled two-wire mode drives lines only low, releasing them high.
// RULE25: one baud interval is the count from reload value down to zero.
package i2c_seq_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BUFFER = 8'h0C;
  localparam logic [7:0] OFF_RELOAD = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  // first control register fields
  localparam int C1_ENABLE = 5;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_TWO_WIRE_MIN = 4'h6;
  // second control register fields
  localparam int C2_START = 0;
  localparam int C2_RESTART = 1;
  localparam int C2_STOP = 2;
  localparam int C2_RECEIVE = 3;
  localparam int C2_ACK = 4;
  localparam int C2_ACKSTAT = 6;
  // status and flag fields
  localparam int ST_FULL = 0;
  localparam int ST_START_SEEN = 3;
  localparam int ST_STOP_SEEN = 4;
  localparam int FL_IRQ = 0;
  localparam int FL_WRITE_COLLISION_FLAG = 1;
  localparam int FL_BCOL = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_START_A = 4'b0001,
    S_START_B = 4'b0010,
    S_RS_PULL = 4'b0011,
    S_RS_SDAHI = 4'b0100,
    S_RS_REL = 4'b0101,
    S_RS_HOLD = 4'b0110,
    S_RS_SDALO = 4'b0111,
    S_TX_LOW = 4'b1000,
    S_TX_REL = 4'b1001,
    S_TX_HIGH = 4'b1010,
    S_SP_LOW = 4'b1011,
    S_SP_REL = 4'b1100,
    S_SP_HIGH = 4'b1101,
    S_SP_DONE = 4'b1110
  } seq_state_e;

  // open-drain drive of both lines; out is always low
  typedef struct packed {
    logic sclOut;
    logic sclOe;
    logic sdaOut;
    logic sdaOe;
  } line_drive_s;
endpackage : i2c_seq_pkg

/* File: hdl/baud_tick_gen.sv */
// baud tick generator: quarter-phase divider and reload down-counter
`timescale 1ns/100ps
module baud_tick_gen
  import i2c_seq_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic halt,
  input wire logic load,
  input wire logic [CNT_W-1:0] reloadVal,
  output logic expired
);
  logic [1:0] phase;
  logic [CNT_W-1:0] count;
  logic running;
  logic tick;

  // refused at elaboration; the counter is sized for a short reload field
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
    $error("baud_tick_gen: CNT_W out of range");
  end

  // phase 1 and 3 stand for the second and fourth quarter phases
  assign tick = phase[0]; // RULE7
  // one interval is reload+1 ticks, the count from the value down to zero inclusive
  assign expired = running && tick && (count == '0); // RULE25

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // counter stops itself at zero until the next load
  always_ff @(posedge clock) begin
    if (sys_rst || halt) begin
      count <= '0;
      running <= 1'b0;
    end else if (load) begin
      count <= reloadVal; // RULE6
      running <= 1'b1;
    end else if (tick && running) begin
      if (count == '0) begin
        running <= 1'b0; // RULE6
      end else begin
        count <= count - 1'b1; // RULE7
      end
    end
  end
endmodule : baud_tick_gen

/* File: hdl/i2c_master_sequencer.sv */
// two-wire master sequencer with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module i2c_master_sequencer
  import i2c_seq_pkg::*;
#(
  parameter int RELOAD_W = 7
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sclIn,
  input wire logic sdaIn,
  output line_drive_s lineDrive
);
  // the field slices below assume the seven-bit reload; refuse anything else
  if (RELOAD_W != 7) begin : g_bad_width
    $error("i2c_master_sequencer: reload width must be 7");
  end

  // user-visible state
  logic portEnable;
  logic [3:0] portMode;
  logic startReq;
  logic restartReq;
  logic stopReq;
  logic rcvReq;
  logic ackReq;
  logic ackStat;
  logic [7:0] transferBuffer;
  logic bufFull;
  logic [7:0] reloadValue;
  logic startSeen;
  logic stopSeen;
  logic irqFlag;
  logic wcolFlag;
  logic bcolFlag;
  // sequencer state
  seq_state_e state;
  logic sclLow;
  logic sdaLow;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic baudLoad;
  logic [RELOAD_W-1:0] baudVal;
  logic baudExpired;
  wire [1:0] syncB;
  logic sclS;
  logic sdaS;

  // two-wire mode decode is used for the line drivers only; the sequencer enable uses the master decode
  function automatic logic twoWire(input logic en, input logic [3:0] mode);
    twoWire = en && (mode >= MODE_TWO_WIRE_MIN);
  endfunction : twoWire

  // two flops per pin; only the second flop feeds any logic
  wire [1:0] pinLevel = {sdaIn, sclIn};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic firstFf;
      logic secondFf;
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          firstFf <= 1'b1;
          secondFf <= 1'b1;
        end else begin
          firstFf <= pinLevel[gi];
          secondFf <= firstFf;
        end
      end
      assign syncB[gi] = secondFf;
    end
  endgenerate
  assign sclS = syncB[0];
  assign sdaS = syncB[1];

  // master decode gates the counter as well as the sequencer
  wire masterOn = portEnable && (portMode == MODE_MASTER);

  // counter half; loads are registered so they land one cycle later
  baud_tick_gen #(
    .CNT_W(RELOAD_W)
  ) u_baud (
    .clock(clock),
    .sys_rst(sys_rst),
    .halt(!masterOn),
    .load(baudLoad),
    .reloadVal(baudVal),
    .expired(baudExpired)
  );

  // register bus decode
  wire wrFire = awvalid && wvalid && !bvalid;
  wire wrLow = wrFire && wstrb[0];
  wire wrCtrl1 = wrLow && (awaddr == OFF_CTRL1);
  wire wrCtrl2 = wrLow && (awaddr == OFF_CTRL2);
  wire wrBuffer = wrLow && (awaddr == OFF_BUFFER);
  wire wrReload = wrLow && (awaddr == OFF_RELOAD);
  wire wrFlags = wrLow && (awaddr == OFF_FLAGS);
  wire wrMapped = (awaddr == OFF_CTRL1) || (awaddr == OFF_CTRL2) ||
                  (awaddr == OFF_STATUS) || (awaddr == OFF_BUFFER) ||
                  (awaddr == OFF_RELOAD) || (awaddr == OFF_FLAGS);
  wire [7:0] wByte = wdata[7:0];
  wire idleNow = (state == S_IDLE);
  // no queueing: a pending start, restart or stop request counts as a running event
  wire seqBusy = !idleNow || startReq || restartReq || stopReq; // RULE5
  wire bufAccept = wrBuffer && !seqBusy && masterOn;
  wire bufRefused = wrBuffer && seqBusy; // RULE14 RULE21
  wire ctrl2Open = !seqBusy; // RULE15 RULE19 RULE21

  assign awready = wrFire;
  assign wready = wrFire;
  assign arready = !rvalid;

  // read data mux, narrow registers sit in the low byte
  wire [7:0] ctrl1Rd = {2'b00, portEnable, 1'b0, portMode};
  wire [7:0] ctrl2Rd = {1'b0, ackStat, 1'b0, ackReq, rcvReq, stopReq,
                        restartReq, startReq};
  wire [7:0] statRd = {3'b000, stopSeen, startSeen, 2'b00, bufFull};
  wire [7:0] flagRd = {5'b00000, bcolFlag, wcolFlag, irqFlag};
  wire rdMapped = (araddr == OFF_CTRL1) || (araddr == OFF_CTRL2) ||
                  (araddr == OFF_STATUS) || (araddr == OFF_BUFFER) ||
                  (araddr == OFF_RELOAD) || (araddr == OFF_FLAGS);
  wire [7:0] rdByte = (araddr == OFF_CTRL1) ? ctrl1Rd :
                      (araddr == OFF_CTRL2) ? ctrl2Rd :
                      (araddr == OFF_STATUS) ? statRd :
                      (araddr == OFF_BUFFER) ? transferBuffer :
                      (araddr == OFF_RELOAD) ? reloadValue :
                      (araddr == OFF_FLAGS) ? flagRd : RESET_BYTE;

  // only release-to-float or pull-low; out stays zero
  assign lineDrive.sclOut = 1'b0;
  assign lineDrive.sdaOut = 1'b0;
  assign lineDrive.sclOe = twoWire(portEnable, portMode) && sclLow; // RULE24
  assign lineDrive.sdaOe = twoWire(portEnable, portMode) && sdaLow; // RULE24

  // write response: one cycle after both channels are taken
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel: data registered on the address handshake
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rdByte};
      rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // configuration written by software, never touched by the sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      portEnable <= 1'b0;
      portMode <= 4'h0;
      reloadValue <= RESET_BYTE;
    end else begin
      if (wrCtrl1) begin
        portEnable <= wByte[C1_ENABLE]; // RULE4
        portMode <= wByte[3:0]; // RULE4
      end
      if (wrReload) begin
        reloadValue <= wByte;
      end
    end
  end

  // sticky flags: write one clears, a hardware set in the same cycle wins
  wire irqSet = masterOn && baudExpired &&
                ((state == S_START_B) || (state == S_RS_SDALO) ||
                 (state == S_SP_DONE) ||
                 ((state == S_TX_HIGH) && (bitCnt == LAST_BIT))); // RULE3
  wire bcolStart = masterOn && (((state == S_IDLE) && startReq &&
                   !sclS && !sdaS) ||
                   ((state == S_START_A) && !sclS)); // RULE13
  wire bcolRestart = masterOn && (((state == S_RS_REL) && sclS && !sdaS) ||
                     ((state == S_RS_HOLD) && !sclS)); // RULE20
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqFlag <= 1'b0;
      wcolFlag <= 1'b0;
      bcolFlag <= 1'b0;
    end else begin
      if (wrFlags && wByte[FL_IRQ]) begin
        irqFlag <= 1'b0;
      end
      if (wrFlags && wByte[FL_WRITE_COLLISION_FLAG]) begin
        wcolFlag <= 1'b0;
      end
      if (wrFlags && wByte[FL_BCOL]) begin
        bcolFlag <= 1'b0;
      end
      if (irqSet) begin
        irqFlag <= 1'b1; // RULE3
      end
      if (bufRefused) begin
        wcolFlag <= 1'b1; // RULE5 RULE14 RULE21
      end
      if (bcolStart || bcolRestart) begin
        bcolFlag <= 1'b1; // RULE13 RULE20
      end
    end
  end

  // sequencer: start, repeated start, byte transmit and stop
  always_ff @(posedge clock) begin
    baudLoad <= 1'b0;
    if (sys_rst) begin
      state <= S_IDLE;
      sclLow <= 1'b0;
      sdaLow <= 1'b0;
      startReq <= 1'b0;
      restartReq <= 1'b0;
      stopReq <= 1'b0;
      rcvReq <= 1'b0;
      ackReq <= 1'b0;
      ackStat <= 1'b0;
      transferBuffer <= RESET_BYTE;
      bufFull <= 1'b0;
      startSeen <= 1'b0; // RULE1
      stopSeen <= 1'b0; // RULE1
      shiftReg <= RESET_BYTE;
      bitCnt <= 4'h0;
      baudVal <= '0;
    end else begin
      if (wrCtrl2 && ctrl2Open) begin
        startReq <= wByte[C2_START];
        restartReq <= wByte[C2_RESTART]; // RULE19
        stopReq <= wByte[C2_STOP];
        rcvReq <= wByte[C2_RECEIVE];
        ackReq <= wByte[C2_ACK];
      end
      if (bufAccept) begin
        transferBuffer <= wByte;
      end
      if (!masterOn) begin
        // disabled port: release both lines and forget bus history
        state <= S_IDLE;
        sclLow <= 1'b0;
        sdaLow <= 1'b0;
        startSeen <= 1'b0; // RULE1
        stopSeen <= 1'b0; // RULE1
      end else begin
        case (state)
          S_IDLE: begin
            if (startReq) begin
              if (sclS && sdaS) begin
                baudVal <= reloadValue[6:0]; // RULE10
                baudLoad <= 1'b1;
                state <= S_START_A;
              end else if (!sclS && !sdaS) begin
                startReq <= 1'b0; // RULE13
              end
            end else if (restartReq) begin
              sclLow <= 1'b1; // RULE16
              state <= S_RS_PULL;
            end else if (stopReq) begin
              sclLow <= 1'b1;
              sdaLow <= 1'b1;
              state <= S_SP_LOW;
            end else if (bufAccept) begin
              // address byte first, then data; each ends with an ack slot
              shiftReg <= wByte; // RULE22
              bufFull <= 1'b1;
              bitCnt <= 4'h0;
              sclLow <= 1'b1;
              sdaLow <= !wByte[7];
              baudVal <= reloadValue[6:0]; // RULE9
              baudLoad <= 1'b1;
              state <= S_TX_LOW;
            end
          end
          S_START_A: begin
            if (!sclS) begin
              startReq <= 1'b0; // RULE13
              state <= S_IDLE;
            end else if (baudExpired) begin
              if (sdaS) begin
                sdaLow <= 1'b1; // RULE11
                startSeen <= 1'b1; // RULE11
                stopSeen <= 1'b0;
                baudVal <= reloadValue[6:0]; // RULE11
                baudLoad <= 1'b1;
                state <= S_START_B;
              end else begin
                startReq <= 1'b0;
                state <= S_IDLE;
              end
            end
          end
          S_START_B: begin
            if (baudExpired) begin
              startReq <= 1'b0; // RULE12
              state <= S_IDLE; // RULE12
            end
          end
          S_RS_PULL: begin
            if (!sclS) begin
              sdaLow <= 1'b0; // RULE16
              baudVal <= {1'b0, reloadValue[5:0]}; // RULE16
              baudLoad <= 1'b1;
              state <= S_RS_SDAHI;
            end
          end
          S_RS_SDAHI: begin
            if (baudExpired && sdaS) begin
              sclLow <= 1'b0; // RULE17
              state <= S_RS_REL;
            end
          end
          S_RS_REL: begin
            if (sclS) begin
              if (!sdaS) begin
                restartReq <= 1'b0; // RULE20
                state <= S_IDLE;
              end else begin
                baudVal <= reloadValue[6:0]; // RULE8 RULE17
                baudLoad <= 1'b1;
                state <= S_RS_HOLD;
              end
            end
          end
          S_RS_HOLD: begin
            if (!sclS) begin
              restartReq <= 1'b0; // RULE20
              state <= S_IDLE;
            end else if (baudExpired) begin
              sdaLow <= 1'b1; // RULE17
              startSeen <= 1'b1; // RULE18
              stopSeen <= 1'b0;
              baudVal <= reloadValue[6:0];
              baudLoad <= 1'b1;
              state <= S_RS_SDALO;
            end
          end
          S_RS_SDALO: begin
            if (baudExpired) begin
              restartReq <= 1'b0; // RULE18
              state <= S_IDLE; // RULE18
            end
          end
          S_TX_LOW: begin
            if (baudExpired) begin
              sclLow <= 1'b0;
              state <= S_TX_REL;
            end
          end
          S_TX_REL: begin
            // a slave stretching SCL holds the count off here
            if (sclS) begin
              baudVal <= reloadValue[6:0]; // RULE8
              baudLoad <= 1'b1;
              state <= S_TX_HIGH;
            end
          end
          S_TX_HIGH: begin
            if (baudExpired) begin
              sclLow <= 1'b1;
              if (bitCnt == LAST_BIT) begin
                ackStat <= sdaS; // RULE23
                sdaLow <= 1'b0;
                state <= S_IDLE; // RULE9
              end else begin
                bitCnt <= bitCnt + 4'h1;
                shiftReg <= {shiftReg[6:0], 1'b0};
                sdaLow <= (bitCnt == 4'h7) ? 1'b0 : !shiftReg[6];
                if (bitCnt == 4'h7) begin
                  bufFull <= 1'b0;
                end
                baudVal <= reloadValue[6:0];
                baudLoad <= 1'b1;
                state <= S_TX_LOW;
              end
            end
          end
          S_SP_LOW: begin
            if (!sdaS) begin
              baudVal <= reloadValue[6:0];
              baudLoad <= 1'b1;
              state <= S_SP_REL;
            end
          end
          S_SP_REL: begin
            if (baudExpired) begin
              sclLow <= 1'b0;
              state <= S_SP_HIGH;
            end
          end
          S_SP_HIGH: begin
            if (sclS && !baudLoad) begin
              baudVal <= reloadValue[6:0]; // RULE8
              baudLoad <= 1'b1;
              sdaLow <= 1'b0;
              state <= S_SP_DONE;
            end
          end
          S_SP_DONE: begin
            if (sdaS && sclS && !stopSeen) begin
              stopSeen <= 1'b1;
              startSeen <= 1'b0;
            end
            if (baudExpired) begin
              stopReq <= 1'b0;
              state <= S_IDLE;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule : i2c_master_sequencer

/* File: sim/i2c_slave_model.sv */
// far-side model: pull-ups, one acknowledging slave, clock stretching
`timescale 1ns/100ps
module i2c_slave_model (
  input wire logic clock,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic ackOn,
  input wire logic [7:0] stretch,
  input wire logic holdLow,
  output logic scl,
  output logic sda,
  output logic [7:0] rxByte
);
  logic sclPrev = 1'h1, sdaPrev = 1'h1, ackDrv = 1'h0;
  logic [3:0] bitCnt = 4'h0;
  logic [7:0] hold = 8'h00;
  initial rxByte = 8'h00;
  // wired-and with pull-ups; holdLow jams both lines for collision cases
  assign scl = !(sclOe || holdLow || hold != 8'h00);
  assign sda = !(sdaOe || holdLow || ackDrv);
  // edge detection on the clock; stretch holds SCL after every fall
  always @(posedge clock) begin
    sclPrev <= scl;
    sdaPrev <= sda;
    if (hold != 8'h00) hold <= hold - 8'h01;
    if (scl && sclPrev && sdaPrev && !sda) begin
      bitCnt <= 4'h0;
    end else if (scl && !sclPrev) begin
      if (bitCnt < 4'h8) rxByte <= {rxByte[6:0], sda};
      bitCnt <= bitCnt + 4'h1;
    end else if (!scl && sclPrev) begin
      hold <= stretch;
      ackDrv <= ackOn && bitCnt == 4'h8;
      if (bitCnt == 4'h9) bitCnt <= 4'h0;
    end
  end
endmodule : i2c_slave_model

/* File: sim/i2c_master_sequencer_asserts.sv */
// concurrent checks on the sequencer's bus and line ports
`timescale 1ns/100ps
module i2c_master_sequencer_asserts
  import i2c_seq_pkg::*;
#(
  parameter int RELOAD_W = 7
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic sclIn,
  input wire line_drive_s lineDrive
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence wrTaken; awvalid && wvalid && awready; endsequence
  sequence rdTaken; arvalid && arready; endsequence
  a_wr_answer: assert property (wrTaken |=> bvalid) else $error("write unanswered");
  a_rd_answer: assert property (rdTaken |=> rvalid && rdata[31:8] == 24'h000000)
    else $error("read unanswered");
  a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_aw_gate: assert property (bvalid |-> !awready) else $error("write taken while busy");
  a_drive_low: assert property (!lineDrive.sclOut && !lineDrive.sdaOut)
    else $error("line driven high");
  // a stretched clock must not be cut short by the sequencer
  a_scl_wait_high: assert property (
    !lineDrive.sclOe && !sclIn && $past(!lineDrive.sclOe) |=> !lineDrive.sclOe)
    else $error("clock pulled during stretch");
  a_scl_min_low: assert property ($rose(lineDrive.sclOe) |=> lineDrive.sclOe)
    else $error("clock low too short");
  a_sda_fall_high: assert property ($rose(lineDrive.sdaOe) && !lineDrive.sclOe |-> sclIn)
    else $error("data pulled with clock low");
endmodule : i2c_master_sequencer_asserts
bind i2c_master_sequencer i2c_master_sequencer_asserts #(.RELOAD_W(RELOAD_W))
  i2c_master_sequencer_asserts_i (.clock(clock), .sys_rst(sys_rst), .awvalid(awvalid),
  .wvalid(wvalid), .awready(awready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .sclIn(sclIn), .lineDrive(lineDrive));

/* File: sim/testbench.sv */
// self-checking bench for the two-wire master sequencer
`timescale 1ns/100ps
module testbench;
  import i2c_seq_pkg::*;
  typedef struct packed {logic w; logic [7:0] a, d, q; logic [1:0] r;} row_s;
  logic clock = 1'h0, sys_rst = 1'h1, ackOn = 1'h1, holdLow = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, stretch = 8'h00, rxByte, q;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, sclIn, sdaIn;
  line_drive_s lineDrive;
  int fails = 0, n_compared = 0;
  row_s rows [7] = '{'{1'h0, OFF_STATUS, 8'h00, 8'h00, RESP_OKAY},
    '{1'h1, OFF_RELOAD, 8'h08, 8'h00, RESP_OKAY}, '{1'h0, OFF_RELOAD, 8'h00, 8'h08, RESP_OKAY},
    '{1'h1, OFF_CTRL1, 8'h28, 8'h00, RESP_OKAY}, '{1'h0, OFF_CTRL1, 8'h00, 8'h28, RESP_OKAY},
    '{1'h1, 8'h18, 8'h00, 8'h00, RESP_SLVERR}, '{1'h0, 8'h18, 8'h00, 8'h00, RESP_SLVERR}};
  i2c_master_sequencer i2c_master_sequencer_i (.clock(clock), .sys_rst(sys_rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sclIn(sclIn), .sdaIn(sdaIn), .lineDrive(lineDrive));
  i2c_slave_model i2c_slave_model_i (.clock(clock), .sclOe(lineDrive.sclOe),
    .sdaOe(lineDrive.sdaOe), .ackOn(ackOn), .stretch(stretch), .holdLow(holdLow),
    .scl(sclIn), .sda(sdaIn), .rxByte(rxByte));
  always #20 clock = !clock;
  task automatic finish_test;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one register access; each channel held until its handshake, write address and data until both are taken
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    if (w) begin
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
    end else begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
    end
    do begin @(posedge clock); n++; end while (!(w ? awready && wready : arready) && n < 40);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    arvalid <= 1'h0;
    do begin @(posedge clock); n++; end while (!(w ? bvalid : rvalid) && n < 40);
    bready <= 1'h0;
    rready <= 1'h0;
    q = rdata[7:0];
    r = w ? bresp : rresp;
    if (n >= 40) begin
      chk(8'h00, 8'h01);
      finish_test();
    end
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(q & m, e);
  endtask : rdchk
  // polling is slow but keeps every wait bounded
  task automatic waitf(input logic [7:0] m);
    for (int k = 0; k < 300; k++) begin
      bus(1'h0, OFF_FLAGS, 8'h00);
      if ((q & m) !== 8'h00) break;
    end
    chk(q & m, m);
    if ((q & m) !== m) finish_test();
  endtask : waitf
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'h0;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      chk({6'h00, r}, {6'h00, rows[i].r});
      if (!rows[i].w && rows[i].r === RESP_OKAY) chk(q, rows[i].q);
    end
    bus(1'h1, OFF_CTRL2, 8'h01);
    bus(1'h1, OFF_BUFFER, 8'hA5);
    bus(1'h1, OFF_CTRL2, 8'h04);
    rdchk(OFF_FLAGS, 8'h02, 8'h02);
    rdchk(OFF_CTRL2, 8'h07, 8'h01);
    waitf(8'h01);
    rdchk(OFF_STATUS, 8'h08, 8'h08);
    rdchk(OFF_CTRL2, 8'h01, 8'h00);
    chk({7'h00, lineDrive.sdaOe}, 8'h01);
    bus(1'h1, OFF_FLAGS, 8'h07);
    stretch <= 8'h28;
    bus(1'h1, OFF_BUFFER, 8'hA4);
    waitf(8'h01);
    chk(rxByte, 8'hA4);
    rdchk(OFF_CTRL2, 8'h40, 8'h00);
    chk({7'h00, lineDrive.sclOe}, 8'h01);
    bus(1'h1, OFF_FLAGS, 8'h07);
    ackOn <= 1'h0;
    stretch <= 8'h00;
    bus(1'h1, OFF_BUFFER, 8'h3C);
    bus(1'h1, OFF_CTRL2, 8'h02);
    waitf(8'h01);
    chk(rxByte, 8'h3C);
    rdchk(OFF_CTRL2, 8'h42, 8'h40);
    bus(1'h1, OFF_FLAGS, 8'h07);
    bus(1'h1, OFF_CTRL2, 8'h02);
    bus(1'h1, OFF_BUFFER, 8'h11);
    rdchk(OFF_FLAGS, 8'h02, 8'h02);
    waitf(8'h01);
    rdchk(OFF_CTRL2, 8'h02, 8'h00);
    rdchk(OFF_STATUS, 8'h08, 8'h08);
    chk({7'h00, lineDrive.sdaOe}, 8'h01);
    bus(1'h1, OFF_FLAGS, 8'h07);
    bus(1'h1, OFF_CTRL2, 8'h04);
    waitf(8'h01);
    rdchk(OFF_STATUS, 8'h10, 8'h10);
    holdLow <= 1'h1;
    bus(1'h1, OFF_FLAGS, 8'h07);
    bus(1'h1, OFF_CTRL2, 8'h01);
    waitf(8'h04);
    rdchk(OFF_CTRL2, 8'h01, 8'h00);
    holdLow <= 1'h0;
    bus(1'h1, OFF_CTRL1, 8'h00);
    rdchk(OFF_STATUS, 8'h18, 8'h00);
    wstrb <= 4'h0;
    bus(1'h1, OFF_RELOAD, 8'h55);
    wstrb <= 4'hF;
    rdchk(OFF_RELOAD, 8'hFF, 8'h08);
    finish_test();
  end
endmodule : testbench
